// ===== hdl/dtb_pkg.sv
package dtb_pkg;

  // ----------------------------------------------------------------
  // organisation
  // ----------------------------------------------------------------
  localparam int DTB_LANES = 4;
  localparam int DTB_LANE_W = 9;
  localparam int DTB_DW = DTB_LANES * DTB_LANE_W;
  localparam int DTB_ADDR_W = 20;

  // ----------------------------------------------------------------
  // beat schedule: beats counted from the command's k rise (beat 0)
  // ----------------------------------------------------------------
  localparam int DTB_SLOTS = 7;
  localparam int DTB_SLOT_A_NORMAL = 5;
  localparam int DTB_SLOT_A_LEGACY = 2;
  localparam int DTB_BUF_DEPTH = 2;
  localparam logic [1:0] DTB_COUNT_RST = 2'h0;
  localparam logic DTB_CLK_PARK = 1'b1;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic kClk;
    logic kClkN;
    logic loadSelectN;
    logic readWrite;
    logic pllDisableN;
  } dtb_ctrl_s;

  typedef struct packed {
    logic valid;
    logic [DTB_ADDR_W-1:0] addr;
    logic hi;
  } dtb_slot_s;

  typedef struct packed {
    logic [DTB_ADDR_W-1:0] addr;
    logic hi;
    logic [DTB_DW-1:0] data;
    logic [DTB_LANES-1:0] be;
  } dtb_wr_s;

endpackage

// ===== hdl/dtb_sram_array.sv
`timescale 1ns/1ns
module dtb_sram_array #(
  parameter int LANES = 4,
  parameter int LANE_W = 9,
  parameter int AW = 21
) (
  input wire logic clock,
  input wire logic rdEn,
  input wire logic [AW-1:0] rdAddr,
  output logic [LANES*LANE_W-1:0] rdData,
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [LANES*LANE_W-1:0] wrData,
  input wire logic [LANES-1:0] wrBe
);

  logic [LANES*LANE_W-1:0] mem [0:(1<<AW)-1];
  logic [LANES*LANE_W-1:0] rdData_reg;

  assign rdData = rdData_reg;

  // ----------------------------------------------------------------
  // read port: data only change on a read, so they hold between beats
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rdEn) begin
      rdData_reg <= mem[rdAddr];
    end
  end

  // ----------------------------------------------------------------
  // lane-masked write: unselected lanes keep their contents
  // ----------------------------------------------------------------
  // one process owns the whole array; lanes are gated inside it
  always_ff @(posedge clock) begin
    for (int i = 0; i < LANES; i++) begin
      // a lane whose select is off is skipped, so all-off writes nothing
      if (wrEn && wrBe[i]) begin
        mem[wrAddr][i*LANE_W +: LANE_W] <= wrData[i*LANE_W +: LANE_W];
      end
    end
  end

endmodule

// ===== hdl/dtb_port.sv
`timescale 1ns/1ns
// Function
// - write taken at k rise; word A next k rise, word A+1 next k# rise.
// - read taken at k rise; A on k# of t+2, A+1 on k of t+3.
// - with clocks stopped the data outputs hold their last state.
// - after power-up deselected, data outputs tristated until first access.
// - first word uses latched address A, second word burst position A+1.
// - x18: select 0 gates bits 8:0, select 1 bits 17:9.
// - x36: four selects gate lanes 8:0, 17:9, 26:18, 35:27.
// - all selects high on a beat writes nothing for that beat.
// - byte selects are sampled separately on each data beat.
// - write data taken and read data launched on both clock rises.
// - pll disable low gives legacy one-cycle read latency.
module dtb_port (
  input wire logic clock,
  input wire logic rst,
  input wire logic kClk,
  input wire logic kClkN,
  input wire logic loadSelectN,
  input wire logic readWrite,
  input wire logic pllDisableN,
  input wire logic [dtb_pkg::DTB_ADDR_W-1:0] addr,
  input wire logic [dtb_pkg::DTB_LANES-1:0] byteWriteSelectN,
  input wire logic [dtb_pkg::DTB_DW-1:0] dqIn,
  output logic [dtb_pkg::DTB_DW-1:0] dqOut,
  output logic dqOe,
  output logic writeOverrun
);
  import dtb_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  dtb_ctrl_s ctrlMeta_reg, ctrlSync_reg;
  logic [DTB_ADDR_W-1:0] addrMeta_reg, addrSync_reg;
  logic [DTB_LANES-1:0] bwsMeta_reg, bwsSync_reg;
  logic [DTB_DW-1:0] dqMeta_reg, dqSync_reg;

  // data pins share the clock pins' delay, so a detected edge sees
  // the data that stood beside it
  always_ff @(posedge clock) begin
    ctrlMeta_reg <= '{kClk, kClkN, loadSelectN, readWrite, pllDisableN};
    ctrlSync_reg <= ctrlMeta_reg;
    addrMeta_reg <= addr;
    addrSync_reg <= addrMeta_reg;
    bwsMeta_reg <= byteWriteSelectN;
    bwsSync_reg <= bwsMeta_reg;
    dqMeta_reg <= dqIn;
    dqSync_reg <= dqMeta_reg;
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic kPrev_reg, kPrev_next;
  logic kNPrev_reg, kNPrev_next;
  dtb_slot_s sched_reg [DTB_SLOTS];
  dtb_slot_s sched_next [DTB_SLOTS];
  logic wrPendValid_reg, wrPendValid_next;
  logic [DTB_ADDR_W-1:0] wrPendAddr_reg, wrPendAddr_next;
  logic wrCurValid_reg, wrCurValid_next;
  logic [DTB_ADDR_W-1:0] wrCurAddr_reg, wrCurAddr_next;
  dtb_wr_s buf_reg [DTB_BUF_DEPTH];
  dtb_wr_s buf_next [DTB_BUF_DEPTH];
  logic [1:0] bufCount_reg, bufCount_next;
  logic [DTB_DW-1:0] dqOut_reg, dqOut_next;
  logic dqOe_reg, dqOe_next;
  logic overrun_reg, overrun_next;

  logic kRise, kNRise, beat, readCmd, writeCmd, legacy;
  logic push, bufReady, bufValid, pop, accept;
  dtb_wr_s pushItem;
  logic memRdEn;
  logic [DTB_ADDR_W:0] memRdAddr;
  logic [DTB_DW-1:0] memRdData;
  int aSlot;

  assign dqOut = dqOut_reg;
  assign dqOe = dqOe_reg;
  assign writeOverrun = overrun_reg;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    kRise = ctrlSync_reg.kClk & ~kPrev_reg;
    kNRise = ctrlSync_reg.kClkN & ~kNPrev_reg;
    // no edge means no beat: a stopped clock freezes everything below except the write buffer draining into the array
    beat = kRise | kNRise;
    legacy = ~ctrlSync_reg.pllDisableN;
    // a high load select starts nothing; read/write is ignored
    readCmd = kRise & ~ctrlSync_reg.loadSelectN & ctrlSync_reg.readWrite;
    writeCmd = kRise & ~ctrlSync_reg.loadSelectN & ~ctrlSync_reg.readWrite;
    kPrev_next = ctrlSync_reg.kClk;
    kNPrev_next = ctrlSync_reg.kClkN;
    aSlot = legacy ? DTB_SLOT_A_LEGACY : DTB_SLOT_A_NORMAL;

    // read schedule: one slot per beat, slot 0 is the beat being driven
    for (int i = 0; i < DTB_SLOTS; i++) begin
      sched_next[i] = sched_reg[i];
    end
    if (beat) begin
      for (int i = 0; i < DTB_SLOTS - 1; i++) begin
        sched_next[i] = sched_reg[i + 1];
      end
      sched_next[DTB_SLOTS - 1] = '0;
    end
    if (readCmd) begin
      sched_next[aSlot] = '{1'b1, addrSync_reg, 1'b0};
      sched_next[aSlot + 1] = '{1'b1, addrSync_reg, 1'b1};
    end

    // the word for the next beat is fetched one beat early
    memRdEn = beat & sched_next[1].valid;
    memRdAddr = {sched_next[1].addr, sched_next[1].hi};

    dqOut_next = dqOut_reg;
    dqOe_next = dqOe_reg;
    if (beat) begin
      dqOe_next = sched_next[0].valid;
      if (sched_next[0].valid) begin
        dqOut_next = memRdData;
      end
    end

    // write capture
    push = 1'b0;
    pushItem = '0;
    wrPendValid_next = wrPendValid_reg;
    wrPendAddr_next = wrPendAddr_reg;
    wrCurValid_next = wrCurValid_reg;
    wrCurAddr_next = wrCurAddr_reg;
    if (kRise) begin
      if (wrPendValid_reg) begin
        push = 1'b1;
        pushItem = '{wrPendAddr_reg, 1'b0, dqSync_reg, ~bwsSync_reg};
        wrCurValid_next = 1'b1;
        wrCurAddr_next = wrPendAddr_reg;
      end
      wrPendValid_next = writeCmd;
      if (writeCmd) begin
        wrPendAddr_next = addrSync_reg;
      end
    end else if (kNRise && wrCurValid_reg) begin
      push = 1'b1;
      pushItem = '{wrCurAddr_reg, 1'b1, dqSync_reg, ~bwsSync_reg};
      wrCurValid_next = 1'b0;
    end

    // two-entry buffer: a memory read holds off the array write for that clock
    bufValid = bufCount_reg != DTB_COUNT_RST;
    bufReady = bufCount_reg != 2'(DTB_BUF_DEPTH);
    pop = bufValid & ~memRdEn;
    accept = push & bufReady;
    // pins cannot be stalled, so a refused word is dropped and flagged
    overrun_next = overrun_reg | (push & ~bufReady);
    for (int i = 0; i < DTB_BUF_DEPTH; i++) begin
      buf_next[i] = buf_reg[i];
    end
    if (pop) begin
      buf_next[0] = buf_reg[1];
    end
    if (accept) begin
      if (bufCount_reg == DTB_COUNT_RST || (pop && bufCount_reg == 2'h1)) begin
        buf_next[0] = pushItem;
      end else begin
        buf_next[1] = pushItem;
      end
    end
    bufCount_next = bufCount_reg + 2'(accept) - 2'(pop);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      // idle as parked high, so reset release shows no false rise
      kPrev_reg <= DTB_CLK_PARK;
      kNPrev_reg <= DTB_CLK_PARK;
      for (int i = 0; i < DTB_SLOTS; i++) begin
        sched_reg[i] <= '0;
      end
      wrPendValid_reg <= 1'b0;
      wrPendAddr_reg <= '0;
      wrCurValid_reg <= 1'b0;
      wrCurAddr_reg <= '0;
      for (int i = 0; i < DTB_BUF_DEPTH; i++) begin
        buf_reg[i] <= '0;
      end
      bufCount_reg <= DTB_COUNT_RST;
      dqOut_reg <= '0;
      dqOe_reg <= 1'b0;
      overrun_reg <= 1'b0;
    end else begin
      kPrev_reg <= kPrev_next;
      kNPrev_reg <= kNPrev_next;
      for (int i = 0; i < DTB_SLOTS; i++) begin
        sched_reg[i] <= sched_next[i];
      end
      wrPendValid_reg <= wrPendValid_next;
      wrPendAddr_reg <= wrPendAddr_next;
      wrCurValid_reg <= wrCurValid_next;
      wrCurAddr_reg <= wrCurAddr_next;
      for (int i = 0; i < DTB_BUF_DEPTH; i++) begin
        buf_reg[i] <= buf_next[i];
      end
      bufCount_reg <= bufCount_next;
      dqOut_reg <= dqOut_next;
      dqOe_reg <= dqOe_next;
      overrun_reg <= overrun_next;
    end
  end

  // ----------------------------------------------------------------
  // storage array
  // ----------------------------------------------------------------
  dtb_sram_array #(
    .LANES(DTB_LANES),
    .LANE_W(DTB_LANE_W),
    .AW(DTB_ADDR_W + 1)
  ) uArray (
    .clock(clock),
    .rdEn(memRdEn),
    .rdAddr(memRdAddr),
    .rdData(memRdData),
    .wrEn(pop),
    .wrAddr({buf_reg[0].addr, buf_reg[0].hi}),
    .wrData(buf_reg[0].data),
    .wrBe(buf_reg[0].be)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_reset_tristate: assert property (@(posedge clock)
    rst |=> !dqOe)
    else $error("data bus driven right after reset");

  a_stopped_hold: assert property (@(posedge clock) disable iff (rst)
    !beat |=> $stable(dqOut) && $stable(dqOe))
    else $error("data outputs moved without a clock edge");

  a_idle_tristate: assert property (@(posedge clock) disable iff (rst)
    beat && !sched_next[0].valid |=> !dqOe)
    else $error("data bus driven with nothing pending");

  a_read_launch: assert property (@(posedge clock) disable iff (rst)
    beat && sched_next[0].valid |=> dqOe && dqOut == $past(memRdData))
    else $error("read word not launched on its beat");

  a_read_normal: assert property (@(posedge clock) disable iff (rst)
    readCmd && !legacy |=> sched_reg[5].valid && !sched_reg[5].hi
      && sched_reg[6].hi && sched_reg[5].addr == $past(addrSync_reg))
    else $error("normal read not scheduled at k# of t+2");

  a_read_legacy: assert property (@(posedge clock) disable iff (rst)
    readCmd && legacy |=> sched_reg[2].valid && sched_reg[3].valid
      && sched_reg[3].hi)
    else $error("legacy read not scheduled one cycle out");

  a_write_first: assert property (@(posedge clock) disable iff (rst)
    kRise && wrPendValid_reg |-> push && !pushItem.hi
      && pushItem.addr == wrPendAddr_reg)
    else $error("first write word not taken at next k rise");

  a_write_second: assert property (@(posedge clock) disable iff (rst)
    !kRise && kNRise && wrCurValid_reg |-> push && pushItem.hi
      && pushItem.addr == wrCurAddr_reg)
    else $error("second write word not taken at k# rise");

  a_lane_mask: assert property (@(posedge clock) disable iff (rst)
    push |-> pushItem.be == ~bwsSync_reg)
    else $error("byte lanes not taken from this beat's selects");

  a_no_loss: assert property (@(posedge clock) disable iff (rst)
    push && bufReady |=> bufCount_reg == $past(bufCount_reg) + 2'h1
      - 2'($past(pop)))
    else $error("accepted write word not held in the buffer");

  a_reset_quiet: assert property (@(posedge clock)
    $fell(rst) |-> !beat)
    else $error("clock edge seen on reset release");

  a_idle_frozen: assert property (@(posedge clock) disable iff (rst)
    !beat |-> !push && !memRdEn)
    else $error("write or read moved without a clock edge");

  a_write_pairs: assert property (@(posedge clock) disable iff (rst)
    kRise && wrPendValid_reg |=> wrCurValid_reg
      && wrCurAddr_reg == $past(wrPendAddr_reg))
    else $error("second write word not armed after the first");

  a_buf_bound: assert property (@(posedge clock) disable iff (rst)
    bufCount_reg <= 2'(DTB_BUF_DEPTH))
    else $error("write buffer holds more words than it has");

  a_flag_sticky: assert property (@(posedge clock) disable iff (rst)
    writeOverrun |=> writeOverrun)
    else $error("overrun flag cleared without reset");

endmodule

// ===== verif/dtb_ctrl_model.sv
`timescale 1ns/1ns
module dtb_ctrl_model (
  input wire logic clock,
  input wire logic [dtb_pkg::DTB_DW-1:0] dqOut,
  input wire logic dqOe,
  output logic kClk,
  output logic kClkN,
  output logic loadSelectN,
  output logic readWrite,
  output logic [dtb_pkg::DTB_ADDR_W-1:0] addr,
  output logic [dtb_pkg::DTB_LANES-1:0] byteWriteSelectN,
  output logic [dtb_pkg::DTB_DW-1:0] dqIn
);
  import dtb_pkg::*;
  // ----------------------------------------------------------------
  // pin clocks
  // ----------------------------------------------------------------
  // each level held 6 clocks: beat seen after 2, outputs settled by 3
  localparam int HALF = 6;
  logic [DTB_DW-1:0] qK, qKn;
  logic oeK, oeKn;
  initial begin
    kClk = 1'b1;
    kClkN = 1'b1;
    loadSelectN = 1'b1;
    readWrite = 1'b0;
    addr = '0;
    byteWriteSelectN = 4'hf;
    dqIn = '0;
  end
  task automatic kcycle(input logic ld, input logic rw,
      input logic [DTB_ADDR_W-1:0] a, input logic [3:0] b0,
      input logic [DTB_DW-1:0] d0, input logic [3:0] b1,
      input logic [DTB_DW-1:0] d1);
    // leaving the parked state must not swallow the k rise: drop k first
    if (kClk == kClkN) begin
      kClk = 1'b0;
      repeat (HALF) @(negedge clock);
    end
    loadSelectN = ld;
    readWrite = rw;
    addr = a;
    byteWriteSelectN = b0;
    dqIn = d0;
    kClk = 1'b1;
    kClkN = 1'b0;
    repeat (HALF) @(negedge clock);
    qK = dqOut;
    oeK = dqOe;
    byteWriteSelectN = b1;
    dqIn = d1;
    kClk = 1'b0;
    kClkN = 1'b1;
    repeat (HALF) @(negedge clock);
    qKn = dqOut;
    oeKn = dqOe;
  endtask
  // park both high; raising k here is one idle k beat
  task automatic stop(input int n);
    loadSelectN = 1'b1;
    kClk = 1'b1;
    repeat (HALF) @(negedge clock);
    qK = dqOut;
    oeK = dqOe;
    repeat (n) @(negedge clock);
  endtask
endmodule

// ===== verif/tb.sv
`timescale 1ns/1ns
module tb;
  import dtb_pkg::*;
  logic clock, rst, pllDisableN, kClk, kClkN, loadSelectN, readWrite;
  logic dqOe, writeOverrun;
  logic [DTB_ADDR_W-1:0] addr;
  logic [DTB_LANES-1:0] byteWriteSelectN;
  logic [DTB_DW-1:0] dqIn, dqOut, e;
  logic [DTB_DW-1:0] kq [1:3];
  logic [DTB_DW-1:0] knq [1:3];
  logic koe [1:3];
  logic knoe [1:3];
  int nMismatch, nTests;
  dtb_port dtb_port_inst (.clock(clock), .rst(rst), .kClk(kClk),
    .kClkN(kClkN), .loadSelectN(loadSelectN), .readWrite(readWrite),
    .pllDisableN(pllDisableN), .addr(addr),
    .byteWriteSelectN(byteWriteSelectN), .dqIn(dqIn), .dqOut(dqOut),
    .dqOe(dqOe), .writeOverrun(writeOverrun));
  dtb_ctrl_model dtb_ctrl_model_inst (.clock(clock), .dqOut(dqOut),
    .dqOe(dqOe), .kClk(kClk), .kClkN(kClkN), .loadSelectN(loadSelectN),
    .readWrite(readWrite), .addr(addr),
    .byteWriteSelectN(byteWriteSelectN), .dqIn(dqIn));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [DTB_DW-1:0] pat(input int i);
    return DTB_DW'(64'h9a5c3b1e7 * (i + 1));
  endfunction
  task automatic chk(input logic [DTB_DW-1:0] got,
      input logic [DTB_DW-1:0] exp);
    nTests++;
    if (got !== exp) begin
      nMismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input logic ld, input logic rw, input int a,
      input logic [3:0] b0, input int d0, input logic [3:0] b1,
      input int d1);
    dtb_ctrl_model_inst.kcycle(ld, rw, DTB_ADDR_W'(a), b0, pat(d0), b1,
      pat(d1));
  endtask
  task automatic wr(input int a, input logic [3:0] b0, input int d0,
      input logic [3:0] b1, input int d1);
    cyc(1'b0, 1'b0, a, 4'hf, 9, 4'hf, 9);
    cyc(1'b1, 1'b0, 0, b0, d0, b1, d1);
  endtask
  // three idle cycles after each read also give the read-to-write gap
  task automatic rd(input int a);
    cyc(1'b0, 1'b1, a, 4'hf, 9, 4'hf, 9);
    for (int i = 1; i <= 3; i++) begin
      cyc(1'b1, 1'b1, 0, 4'hf, 9, 4'hf, 9);
      kq[i] = dtb_ctrl_model_inst.qK;
      knq[i] = dtb_ctrl_model_inst.qKn;
      koe[i] = dtb_ctrl_model_inst.oeK;
      knoe[i] = dtb_ctrl_model_inst.oeKn;
    end
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk(DTB_DW'(dqOe), '0);
    chk(dqOut, '0);
    cyc(1'b1, 1'b1, 3, 4'h0, 1, 4'h0, 1);
    chk(DTB_DW'(dtb_ctrl_model_inst.oeKn), '0);
    $display("test reset done");
  endtask
  task automatic t_burst;
    cyc(1'b0, 1'b0, 6, 4'hf, 9, 4'hf, 9);
    cyc(1'b0, 1'b0, 7, 4'h0, 2, 4'h0, 3);
    cyc(1'b1, 1'b0, 0, 4'h0, 4, 4'h0, 5);
    rd(6);
    chk(DTB_DW'(koe[2]), '0);
    chk(DTB_DW'(knoe[2]), DTB_DW'(1));
    chk(knq[2], pat(2));
    chk(kq[3], pat(3));
    chk(DTB_DW'(knoe[3]), '0);
    rd(7);
    chk(knq[2], pat(4));
    chk(kq[3], pat(5));
    $display("test burst done");
  endtask
  task automatic t_lanes;
    logic [DTB_DW-1:0] w;
    for (int g = 0; g < DTB_LANES; g++) begin
      wr(8 + g, 4'h0, 6, 4'h0, 7);
      wr(8 + g, ~(4'h1 << g), 8, 4'hf, 8);
      rd(8 + g);
      e = pat(6);
      w = pat(8);
      e[9*g +: 9] = w[9*g +: 9];
      chk(knq[2], e);
      chk(kq[3], pat(7));
    end
    $display("test lanes done");
  endtask
  task automatic t_nop;
    cyc(1'b1, 1'b0, 6, 4'h0, 1, 4'h0, 1);
    cyc(1'b1, 1'b1, 6, 4'h0, 1, 4'h0, 1);
    rd(6);
    chk(knq[2], pat(2));
    chk(kq[3], pat(3));
    $display("test nop done");
  endtask
  task automatic t_stop;
    cyc(1'b0, 1'b1, 7, 4'hf, 9, 4'hf, 9);
    cyc(1'b1, 1'b1, 0, 4'hf, 9, 4'hf, 9);
    cyc(1'b1, 1'b1, 0, 4'hf, 9, 4'hf, 9);
    dtb_ctrl_model_inst.stop(200);
    chk(dtb_ctrl_model_inst.qK, pat(5));
    chk(dqOut, pat(5));
    chk(DTB_DW'(dqOe), DTB_DW'(1));
    cyc(1'b1, 1'b1, 0, 4'hf, 9, 4'hf, 9);
    cyc(1'b1, 1'b1, 0, 4'hf, 9, 4'hf, 9);
    chk(DTB_DW'(dtb_ctrl_model_inst.oeKn), '0);
    $display("test stop done");
  endtask
  task automatic t_legacy;
    pllDisableN = 1'b0;
    cyc(1'b1, 1'b1, 0, 4'hf, 9, 4'hf, 9);
    rd(6);
    chk(DTB_DW'(koe[1]), DTB_DW'(1));
    chk(kq[1], pat(2));
    chk(knq[1], pat(3));
    pllDisableN = 1'b1;
    cyc(1'b1, 1'b1, 0, 4'hf, 9, 4'hf, 9);
    chk(DTB_DW'(writeOverrun), '0);
    $display("test legacy done");
  endtask
  task automatic giveVerdict;
    $display("comparisons %0d mismatches %0d", nTests, nMismatch);
    if (nMismatch == 0 && nTests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // run
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    repeat (20000) @(posedge clock);
    nMismatch++;
    giveVerdict();
  end
  initial begin
    nMismatch = 0;
    nTests = 0;
    rst = 1'b1;
    pllDisableN = 1'b1;
    repeat (20) @(negedge clock);
    rst = 1'b0;
    repeat (4) @(negedge clock);
    t_reset();
    t_burst();
    t_lanes();
    t_nop();
    t_stop();
    t_legacy();
    giveVerdict();
  end
endmodule
